/* File: mri_unit_regs.svh */
/*
 * offsets, field positions, opcodes and reset values of the memory
 * reference unit; assumes a 16-bit word and an 8-bit register address.
 */
`ifndef MRI_UNIT_REGS_SVH
`define MRI_UNIT_REGS_SVH

// register offsets
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_PC 8'h08
`define OFF_ACC_A 8'h0c
`define OFF_ACC_B 8'h10
`define OFF_FLAGS 8'h14

// register fields
`define CTRL_RUN 0
`define STAT_BUSY 0
`define STAT_UNSUP 1
`define FLAG_CARRY 0
`define FLAG_OVF 1

// instruction word fields
`define IW_INDIRECT 15
`define IW_PAGE 10
`define IW_OP_HI 14
`define IW_OP_LO 11
`define IW_ADDR_HI 9

// opcodes in bits 14:11
`define OP_LOAD_A 4'h0
`define OP_LOAD_B 4'h1
`define OP_CMP_A 4'h2
`define OP_CMP_B 4'h3
`define OP_ADD_A 4'h4
`define OP_ADD_B 4'h5
`define OP_STORE_A 4'h6

// reset values
`define RST_PC 16'h0000
`define RST_WORD 16'h0000

`endif

/* File: mri_pkg.sv */
/*
 * types of the memory reference unit: states, processor state,
 * memory request and adder result; assumes mri_unit_regs.svh.
 */
package mri_pkg;

    typedef enum logic [2:0] {sIdle, sFetch, sDecode, sIndir, sExec} state_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] accA;
        logic [15:0] accB;
        logic [15:0] ir;
        logic carry;
        logic ovf;
    } cpu_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic [15:0] word;
        logic carry;
        logic ovf;
    } sum_t;

endpackage : mri_pkg

/* File: memory_reference_instruction_unit.sv */
/*
 * memory reference instruction unit: fetch, page and indirect
 * addressing, load, compare-and-skip and add on two accumulators, store of the first.
 * assumes a synchronous word memory on clk answering a read one cycle
 * after the request, and a register master on the same clock.
 */
// Function
// - sixteen-slot group acting on a referenced word
// - bit 10 picks base or current page
// - bit 15 set fetches the address indirectly
// - load first accumulator from memory
// - load second accumulator from memory
// - first accumulator compare, skip when different
// - second accumulator compare, skip when different
// - add memory into first accumulator
// - carry out of bit 15 sets carry
// - carry 14 xor carry 15 sets overflow
// - second accumulator add behaves the same
// - store first accumulator into memory
`timescale 1ns/1ns
`include "mri_unit_regs.svh"

module memory_reference_instruction_unit
    import mri_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    // word memory
    output mem_req_t memReq,
    input wire logic [15:0] memRdata
);

    ////////////////////////////////////////////////////////////////
    // helpers

    // base page is the bottom of memory, current page keeps pc[15:10]
    function automatic logic [15:0] effAddr(input logic [15:0] iw,
                                            input logic [15:0] pcNow);
        if (iw[`IW_PAGE]) begin
            effAddr = {pcNow[15:`IW_PAGE], iw[`IW_ADDR_HI:0]};
        end else begin
            effAddr = {6'h00, iw[`IW_ADDR_HI:0]};
        end
    endfunction : effAddr

    // flags only ever set here; clearing is software's job
    function automatic sum_t addWord(input logic [15:0] acc,
                                     input logic [15:0] m,
                                     input logic cIn,
                                     input logic vIn);
        logic [16:0] s;
        logic c14;
        s = {1'b0, acc} + {1'b0, m};
        c14 = acc[15] ^ m[15] ^ s[15];
        addWord.word = s[15:0];
        addWord.carry = cIn | s[16];
        addWord.ovf = vIn | (c14 ^ s[16]);
    endfunction : addWord

    ////////////////////////////////////////////////////////////////
    // state

    state_t st;
    state_t next_st;
    cpu_t cpu;
    cpu_t next_cpu;
    logic [15:0] ea;
    logic [15:0] next_ea;
    logic run;
    logic next_run;
    logic unsup;
    logic next_unsup;
    logic [15:0] next_regRdata;
    logic [3:0] op;
    sum_t sumA;
    sum_t sumB;

    assign op = cpu.ir[`IW_OP_HI:`IW_OP_LO];
    // events only, ored in below, so a clear written in the same cycle still takes
    assign sumA = addWord(cpu.accA, memRdata, 1'b0, 1'b0);
    assign sumB = addWord(cpu.accB, memRdata, 1'b0, 1'b0);

    ////////////////////////////////////////////////////////////////
    // sequencer and datapath

    always_comb begin
        next_st = st;
        next_cpu = cpu;
        next_ea = ea;
        next_run = run;
        next_unsup = unsup;
        memReq = '0;
        // software writes first, so hardware sets below win a tie
        if (regWr) begin
            if (regAddr == `OFF_CTRL) begin
                next_run = regWdata[`CTRL_RUN];
            end else if (regAddr == `OFF_STATUS) begin
                next_unsup = unsup & ~regWdata[`STAT_UNSUP];
            end else if (regAddr == `OFF_PC) begin
                next_cpu.pc = regWdata;
            end else if (regAddr == `OFF_ACC_A) begin
                next_cpu.accA = regWdata;
            end else if (regAddr == `OFF_ACC_B) begin
                next_cpu.accB = regWdata;
            end else if (regAddr == `OFF_FLAGS) begin
                next_cpu.carry = cpu.carry & ~regWdata[`FLAG_CARRY];
                next_cpu.ovf = cpu.ovf & ~regWdata[`FLAG_OVF];
            end
        end
        case (st)
            sIdle: begin
                if (run) begin
                    next_st = sFetch;
                end
            end
            sFetch: begin
                memReq.rd = 1'b1;
                memReq.addr = cpu.pc;
                next_st = sDecode;
            end
            sDecode: begin
                next_cpu.ir = memRdata;
                next_ea = effAddr(memRdata, cpu.pc);
                memReq.addr = effAddr(memRdata, cpu.pc);
                if (memRdata[`IW_INDIRECT]) begin
                    memReq.rd = 1'b1;
                    next_st = sIndir;
                end else if (memRdata[`IW_OP_HI:`IW_OP_LO] == `OP_STORE_A) begin
                    memReq.wr = 1'b1;
                    memReq.wdata = cpu.accA;
                    next_cpu.pc = cpu.pc + 16'h0001;
                    next_st = run ? sFetch : sIdle;
                end else begin
                    memReq.rd = 1'b1;
                    next_st = sExec;
                end
            end
            sIndir: begin
                // single level: the fetched word is the address itself
                next_ea = memRdata;
                memReq.addr = memRdata;
                if (op == `OP_STORE_A) begin
                    memReq.wr = 1'b1;
                    memReq.wdata = cpu.accA;
                    next_cpu.pc = cpu.pc + 16'h0001;
                    next_st = run ? sFetch : sIdle;
                end else begin
                    memReq.rd = 1'b1;
                    next_st = sExec;
                end
            end
            sExec: begin
                next_cpu.pc = cpu.pc + 16'h0001;
                next_st = run ? sFetch : sIdle;
                case (op)
                    `OP_LOAD_A: begin
                        next_cpu.accA = memRdata;
                    end
                    `OP_LOAD_B: begin
                        next_cpu.accB = memRdata;
                    end
                    `OP_CMP_A: begin
                        if (memRdata != cpu.accA) begin
                            next_cpu.pc = cpu.pc + 16'h0002;
                        end
                    end
                    `OP_CMP_B: begin
                        if (memRdata != cpu.accB) begin
                            next_cpu.pc = cpu.pc + 16'h0002;
                        end
                    end
                    `OP_ADD_A: begin
                        next_cpu.accA = sumA.word;
                        next_cpu.carry = next_cpu.carry | sumA.carry;
                        next_cpu.ovf = next_cpu.ovf | sumA.ovf;
                    end
                    `OP_ADD_B: begin
                        next_cpu.accB = sumB.word;
                        next_cpu.carry = next_cpu.carry | sumB.carry;
                        next_cpu.ovf = next_cpu.ovf | sumB.ovf;
                    end
                    default: begin
                        // other group members live elsewhere; step over them
                        next_unsup = 1'b1;
                    end
                endcase
            end
            default: begin
                next_st = sIdle;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= sIdle;
            cpu <= '{pc: `RST_PC, accA: `RST_WORD, accB: `RST_WORD,
                     ir: `RST_WORD, carry: 1'b0, ovf: 1'b0};
            ea <= `RST_WORD;
            run <= 1'b0;
            unsup <= 1'b0;
        end else begin
            st <= next_st;
            cpu <= next_cpu;
            ea <= next_ea;
            run <= next_run;
            unsup <= next_unsup;
        end
    end

    ////////////////////////////////////////////////////////////////
    // register readback

    always_comb begin
        next_regRdata = 16'h0000;
        if (regRd) begin
            if (regAddr == `OFF_CTRL) begin
                next_regRdata[`CTRL_RUN] = run;
            end else if (regAddr == `OFF_STATUS) begin
                next_regRdata[`STAT_BUSY] = (st != sIdle);
                next_regRdata[`STAT_UNSUP] = unsup;
            end else if (regAddr == `OFF_PC) begin
                next_regRdata = cpu.pc;
            end else if (regAddr == `OFF_ACC_A) begin
                next_regRdata = cpu.accA;
            end else if (regAddr == `OFF_ACC_B) begin
                next_regRdata = cpu.accB;
            end else if (regAddr == `OFF_FLAGS) begin
                next_regRdata[`FLAG_CARRY] = cpu.carry;
                next_regRdata[`FLAG_OVF] = cpu.ovf;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            regRdata <= 16'h0000;
        end else begin
            regRdata <= next_regRdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks

    logic quiet;
    assign quiet = !regWr;

    load_a_a: assert property (@(posedge clk) disable iff (rst)
        st == sExec && op == `OP_LOAD_A && quiet |=> cpu.accA == $past(memRdata))
        else $error("first accumulator load lost");

    load_b_a: assert property (@(posedge clk) disable iff (rst)
        st == sExec && op == `OP_LOAD_B && quiet |=> cpu.accB == $past(memRdata))
        else $error("second accumulator load lost");

    cmp_skip_a: assert property (@(posedge clk) disable iff (rst)
        st == sExec && op == `OP_CMP_A && memRdata != cpu.accA && quiet
        |=> cpu.pc == $past(cpu.pc) + 16'h0002)
        else $error("unequal compare did not skip");

    cmp_equal_a: assert property (@(posedge clk) disable iff (rst)
        st == sExec && op == `OP_CMP_B && memRdata == cpu.accB && quiet
        |=> cpu.pc == $past(cpu.pc) + 16'h0001)
        else $error("equal compare skipped");

    add_sum_a: assert property (@(posedge clk) disable iff (rst)
        st == sExec && op == `OP_ADD_A && quiet
        |=> cpu.accA == $past(cpu.accA) + $past(memRdata))
        else $error("sum wrong");

    carry_sticky_a: assert property (@(posedge clk) disable iff (rst)
        cpu.carry && !(regWr && regAddr == `OFF_FLAGS) |=> cpu.carry)
        else $error("carry cleared by hardware");

    ovf_set_a: assert property (@(posedge clk) disable iff (rst)
        st == sExec && op == `OP_ADD_B
        && (({1'b0, cpu.accB[14:0]} + {1'b0, memRdata[14:0]} > 16'h7fff)
            ^ ({1'b0, cpu.accB} + {1'b0, memRdata} > 17'h0ffff)) |=> cpu.ovf)
        else $error("overflow not set");

    store_word_a: assert property (@(posedge clk) disable iff (rst)
        memReq.wr |-> memReq.wdata == cpu.accA
            && (st == sDecode ? memRdata[`IW_OP_HI:`IW_OP_LO] : op) == `OP_STORE_A)
        else $error("store wrote wrong word");

    indir_path_a: assert property (@(posedge clk) disable iff (rst)
        st == sDecode && memRdata[`IW_INDIRECT] |=> st == sIndir ##1 st != sIndir)
        else $error("indirect step missing");

    page_addr_a: assert property (@(posedge clk) disable iff (rst)
        st == sDecode && memRdata[`IW_PAGE]
        |-> memReq.addr[15:10] == cpu.pc[15:10])
        else $error("current page address wrong");

endmodule : memory_reference_instruction_unit

/* File: word_memory.sv */
/*
 * word memory model on the far side of the memory reference unit.
 * assumes requests sampled on the rising edge of clk and a read answer
 * one cycle after the request.
 */
`timescale 1ns/1ns
module word_memory
    import mri_pkg::*;
(
    // clock
    input wire logic clk,
    // request and answer
    input wire mem_req_t memReq,
    output logic [15:0] memRdata
);
    // only 4k words modelled, upper address bits alias
    logic [15:0] mem [0:4095];
    initial begin
        for (int i = 0; i < 4096; i++) mem[i] = 16'h3800;
        memRdata = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////
    // stale data inverted so a late sample never matches by luck
    always @(posedge clk) begin
        if (memReq.wr) begin
            mem[memReq.addr[11:0]] <= memReq.wdata;
        end
        memRdata <= memReq.rd ? mem[memReq.addr[11:0]] : ~memRdata;
    end
endmodule : word_memory

/* File: testbench.sv */
/*
 * self-checking bench for the memory reference unit: single-steps a
 * program through the run bit and checks registers and memory.
 * assumes word_memory as the far side and one clock.
 */
`timescale 1ns/1ns
`include "mri_unit_regs.svh"
module testbench
    import mri_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdata;
    mem_req_t memReq;
    logic [15:0] memRdata;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [15:0] d;
    logic [15:0] prog [13] = '{16'h0010, 16'h2011, 16'h0c10, 16'h2811, 16'h1012, 16'h8813, 16'h1810,
        16'h0011, 16'h1011, 16'h0811, 16'h3020, 16'h2011, 16'h3800};
    logic [15:0] expA [11] = '{16'h7fff, 16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000,
        16'h8000, 16'h8000, 16'h8001, 16'h8001};
    logic [15:0] expB [11] = '{16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0000, 16'h1234, 16'h1234,
        16'h1234, 16'h1234, 16'h1234, 16'h1234};
    logic [15:0] expF [11] = '{16'h0000, 16'h0002, 16'h0002, 16'h0003, 16'h0003, 16'h0003, 16'h0003,
        16'h0003, 16'h0003, 16'h0003, 16'h0003};
    logic [15:0] expPc [11] = '{16'h0401, 16'h0402, 16'h0403, 16'h0404, 16'h0405, 16'h0406, 16'h0408,
        16'h040a, 16'h040b, 16'h040c, 16'h040d};

    memory_reference_instruction_unit dut (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .memReq(memReq), .memRdata(memRdata)
    );
    word_memory memory (.clk(clk), .memReq(memReq), .memRdata(memRdata));

    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    // tasks are entered right after a rising edge
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 v = regRdata;
        @(posedge clk);
    endtask : rd

    // run high for one edge only, so exactly one instruction runs
    task automatic step();
        logic [15:0] s;
        regWr <= 1'b1;
        regAddr <= `OFF_CTRL;
        regWdata <= 16'h0001;
        @(posedge clk);
        regWdata <= 16'h0000;
        @(posedge clk);
        regWr <= 1'b0;
        for (int k = 0; k < 20; k++) begin
            rd(`OFF_STATUS, s);
            if (s[`STAT_BUSY] === 1'b0) break;
        end
        chk({15'h0000, s[`STAT_BUSY]}, 16'h0000, "still busy");
    endtask : step

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            rd(8'(4 * i), d);
            chk(d, 16'h0000, "reset value");
        end
        rd(8'h18, d);
        chk(d, 16'h0000, "unmapped read");
        $display("test reset values done");

        memory.mem[12'h010] = 16'h7fff;
        memory.mem[12'h011] = 16'h0001;
        memory.mem[12'h012] = 16'h8000;
        memory.mem[12'h013] = 16'h0420;
        memory.mem[12'h420] = 16'h1234;
        memory.mem[12'h410] = 16'hffff;
        for (int i = 0; i < 13; i++) memory.mem[12'h400 + i] = prog[i];
        wr(`OFF_PC, 16'h0400);
        for (int i = 0; i < 11; i++) begin
            step();
            rd(`OFF_ACC_A, d);
            chk(d, expA[i], "first accumulator");
            rd(`OFF_ACC_B, d);
            chk(d, expB[i], "second accumulator");
            rd(`OFF_FLAGS, d);
            chk(d, expF[i], "flags");
            rd(`OFF_PC, d);
            chk(d, expPc[i], "program counter");
        end
        rd(`OFF_STATUS, d);
        chk(d, 16'h0002, "unsupported opcode flag");
        $display("test instruction steps done");

        chk(memory.mem[12'h020], 16'h8000, "stored word");
        chk(memory.mem[12'h011], 16'h0001, "add operand kept");
        chk(memory.mem[12'h012], 16'h8000, "compare operand kept");
        $display("test memory effects done");

        wr(`OFF_FLAGS, 16'h0003);
        rd(`OFF_FLAGS, d);
        chk(d, 16'h0000, "flags cleared");
        wr(`OFF_STATUS, 16'h0002);
        rd(`OFF_STATUS, d);
        chk(d, 16'h0000, "status cleared");
        $display("test flag clearing done");

        memory.mem[12'h40d] = 16'hb013;
        step();
        chk(memory.mem[12'h420], 16'h8001, "indirect store");
        rd(`OFF_PC, d);
        chk(d, 16'h040e, "pc after store");
        wr(`OFF_ACC_B, 16'h7fff);
        wr(`OFF_PC, 16'h0403);
        step();
        rd(`OFF_ACC_B, d);
        chk(d, 16'h8000, "second accumulator sum");
        rd(`OFF_FLAGS, d);
        chk(d, 16'h0002, "second accumulator overflow");
        $display("test indirect store and overflow done");
        complete_run();
    end
endmodule : testbench
